// >>> logic/tuner_pll_three_wire_loader.sv
`timescale 1ns/1ps
// Summary of operation
// - Three-wire mode when format select is high
// - Shift data on bus clock fall, CE high
// - Band bits load on fifth rising edge
// - Short words load divider at CE fall
// - Long word: divider at 20th rise, control at CE fall
// - Long word sets ratio from both selects
// - Control bits other than select A change only on long words
// - 18-bit word: top bit zero, select A one
// - 19-bit word clears select A
// - Under eighteen bits leaves divider unchanged
// - Bit meanings match two-wire byte layout
// - Reset holds all state at defaults
// - Defaults: high pump, test 001, B one
// - Default band ports all off
// - Tuning off until first complete word
// - Select bits choose ratio 640, 1024, 512
// - Pump select and tuning off drive outputs
// - Band bit one turns port on
module tuner_pll_three_wire_loader (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_bus_format_select,
	input  wire logic        i_bus_ce,
	input  wire logic        i_bus_clk,
	input  wire logic        i_bus_data,
	output logic             o_high_band_port,
	output logic             o_low_sub_band_port,
	output logic             o_upper_sub_band_port,
	output logic             o_sound_trap_port,
	output logic [14:0]      o_divider_word,
	output logic             o_pump_current_select,
	output logic [2:0]       o_test_mode_bits,
	output logic             o_ratio_select_a,
	output logic             o_ratio_select_b,
	output logic [10:0]      o_ref_divider_ratio,
	output logic             o_tuning_output_off
);

	tuner_pll_pkg::load_state_t state_q;
	tuner_pll_pkg::load_state_t state_d;

	logic [tuner_pll_pkg::SHIFT_W-1:0] sr_q;
	logic [tuner_pll_pkg::SHIFT_W-1:0] sr_d;
	logic [4:0]                        cnt_q;
	logic [4:0]                        cnt_d;
	logic [tuner_pll_pkg::BAND_W-1:0]  band_q;
	logic [tuner_pll_pkg::BAND_W-1:0]  band_d;
	logic [tuner_pll_pkg::DIV_W-1:0]   div_q;
	logic [tuner_pll_pkg::DIV_W-1:0]   div_d;
	logic                              cp_q;
	logic                              cp_d;
	logic [tuner_pll_pkg::TEST_W-1:0]  test_q;
	logic [tuner_pll_pkg::TEST_W-1:0]  test_d;
	logic                              rsa_q;
	logic                              rsa_d;
	logic                              rsb_q;
	logic                              rsb_d;
	logic                              os_q;
	logic                              os_d;
	logic                              first_q;
	logic                              first_d;
	logic                              tune_off_q;
	logic                              tune_off_d;
	logic [tuner_pll_pkg::RATIO_W-1:0] ratio_q;
	logic [tuner_pll_pkg::RATIO_W-1:0] ratio_d;

	logic ce_high;
	logic ce_fall;
	logic clk_rise;
	logic clk_fall;
	logic bus_data;

	bus_edge_detect u_edge (
		.i_ref_clk  (i_ref_clk),
		.i_rst_n    (i_rst_n),
		.i_bus_ce   (i_bus_ce),
		.i_bus_clk  (i_bus_clk),
		.i_bus_data (i_bus_data),
		.o_ce_high  (ce_high),
		.o_ce_fall  (ce_fall),
		.o_clk_rise (clk_rise),
		.o_clk_fall (clk_fall),
		.o_data     (bus_data)
	);

	// Mode and frame tracking
	wire in_shift = (state_q == tuner_pll_pkg::ST_SHIFT);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			tuner_pll_pkg::ST_OFF: begin
				if (i_bus_format_select && !ce_high) begin
					state_d = tuner_pll_pkg::ST_IDLE;
				end
			end
			tuner_pll_pkg::ST_IDLE: begin
				if (!i_bus_format_select) begin
					state_d = tuner_pll_pkg::ST_OFF;
				end else if (ce_high) begin
					state_d = tuner_pll_pkg::ST_SHIFT;
				end
			end
			tuner_pll_pkg::ST_SHIFT: begin
				if (!i_bus_format_select) begin
					state_d = tuner_pll_pkg::ST_OFF;
				end else if (!ce_high) begin
					state_d = tuner_pll_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = tuner_pll_pkg::ST_OFF;
			end
		endcase
	end

	// Event decode
	wire shift_en  = in_shift && ce_high && clk_fall;
	wire band_load = in_shift && ce_high && clk_rise
		&& (cnt_q == tuner_pll_pkg::BAND_LOAD_CNT);
	wire div_load  = in_shift && ce_high && clk_rise
		&& (cnt_q == tuner_pll_pkg::DIV_LOAD_CNT);
	wire word_end  = in_shift && ce_fall;
	wire end18     = word_end && (cnt_q == tuner_pll_pkg::WORD_SHORT);
	wire end19     = word_end && (cnt_q == tuner_pll_pkg::WORD_MID);
	wire end27     = word_end && (cnt_q == tuner_pll_pkg::WORD_LONG);
	// Other lengths are not loaded at CE fall
	wire word_ok   = end18 || end19 || end27;

	wire cnt_sat   = (cnt_q == tuner_pll_pkg::CNT_MAX);
	wire [4:0] cnt_inc = 5'(cnt_q + tuner_pll_pkg::CNT_ONE);

	// Shift path, newest bit at the bottom
	assign sr_d  = shift_en ? {sr_q[tuner_pll_pkg::SHIFT_W-2:0], bus_data} : sr_q;
	assign cnt_d = (!in_shift || !ce_high) ? tuner_pll_pkg::CNT_ZERO
		: (shift_en && !cnt_sat) ? cnt_inc : cnt_q;

	// Band ports from the first four bits
	assign band_d = band_load ? sr_q[tuner_pll_pkg::BAND_W-1:0] : band_q;

	// Divider word
	wire [tuner_pll_pkg::DIV_W-1:0] div_full  = sr_q[tuner_pll_pkg::DIV_W-1:0];
	wire [tuner_pll_pkg::DIV_W-1:0] div_short = {1'h0, sr_q[tuner_pll_pkg::DIV_SHORT_HI:0]};
	assign div_d = (div_load || end19) ? div_full
		: end18 ? div_short : div_q;

	// Control bits from the long word only
	assign cp_d   = end27 ? sr_q[tuner_pll_pkg::CB_CP] : cp_q;
	assign test_d = end27 ? sr_q[tuner_pll_pkg::CB_T_HI:tuner_pll_pkg::CB_T_LO] : test_q;
	assign rsb_d  = end27 ? sr_q[tuner_pll_pkg::CB_RSB] : rsb_q;
	assign os_d   = end27 ? sr_q[tuner_pll_pkg::CB_OS] : os_q;

	// Select A follows word length or the long word
	assign rsa_d = end18 ? 1'h1
		: end19 ? 1'h0
		: end27 ? sr_q[tuner_pll_pkg::CB_RSA] : rsa_q;

	// Tuning stays off until a complete word
	assign first_d    = first_q || word_ok;
	assign tune_off_d = !first_d || os_d;

	// Reference ratio decode
	assign ratio_d = !rsb_d ? tuner_pll_pkg::RATIO_640
		: rsa_d ? tuner_pll_pkg::RATIO_512 : tuner_pll_pkg::RATIO_1024;

	// Power-on defaults
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			state_q <= tuner_pll_pkg::ST_OFF;
			sr_q    <= '0;
			cnt_q   <= tuner_pll_pkg::CNT_ZERO;
			band_q  <= tuner_pll_pkg::BAND_RST;
			div_q   <= tuner_pll_pkg::DIV_RST;
		end else begin
			state_q <= state_d;
			sr_q    <= sr_d;
			cnt_q   <= cnt_d;
			band_q  <= band_d;
			div_q   <= div_d;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			cp_q       <= tuner_pll_pkg::CP_RST;
			test_q     <= tuner_pll_pkg::TEST_RST;
			rsa_q      <= tuner_pll_pkg::RSA_RST;
			rsb_q      <= tuner_pll_pkg::RSB_RST;
			os_q       <= tuner_pll_pkg::OS_RST;
			first_q    <= 1'h0;
			tune_off_q <= 1'h1;
			ratio_q    <= tuner_pll_pkg::RATIO_1024;
		end else begin
			cp_q       <= cp_d;
			test_q     <= test_d;
			rsa_q      <= rsa_d;
			rsb_q      <= rsb_d;
			os_q       <= os_d;
			first_q    <= first_d;
			tune_off_q <= tune_off_d;
			ratio_q    <= ratio_d;
		end
	end

	// Outputs
	assign o_sound_trap_port     = band_q[tuner_pll_pkg::BB_SOUND_TRAP];
	assign o_high_band_port      = band_q[tuner_pll_pkg::BB_HIGH_BAND];
	assign o_upper_sub_band_port = band_q[tuner_pll_pkg::BB_UPPER_SUB];
	assign o_low_sub_band_port   = band_q[tuner_pll_pkg::BB_LOW_SUB];
	assign o_divider_word        = div_q;
	assign o_pump_current_select = cp_q;
	assign o_test_mode_bits      = test_q;
	assign o_ratio_select_a      = rsa_q;
	assign o_ratio_select_b      = rsb_q;
	assign o_ref_divider_ratio   = ratio_q;
	assign o_tuning_output_off   = tune_off_q;

	// Checks
	property p_mode_off;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(!i_bus_format_select && !in_shift) |=> $stable(div_q) && $stable(band_q);
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("bus changed state outside mode");

	property p_shift;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		shift_en |=> (sr_q[0] == $past(bus_data)) && (sr_q[1] == $past(sr_q[0]));
	endproperty
	a_shift: assert property (p_shift) else $error("bit not shifted on clock fall");

	property p_band;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		band_load |=> o_high_band_port == $past(sr_q[tuner_pll_pkg::BB_HIGH_BAND])
			&& o_sound_trap_port == $past(sr_q[tuner_pll_pkg::BB_SOUND_TRAP]);
	endproperty
	a_band: assert property (p_band) else $error("band ports not loaded");

	property p_div18;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		end18 |=> o_divider_word == {1'h0, $past(sr_q[13:0])} && o_ratio_select_a;
	endproperty
	a_div18: assert property (p_div18) else $error("short word load wrong");

	property p_div19;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		end19 |=> o_divider_word == $past(sr_q[14:0]) && !o_ratio_select_a;
	endproperty
	a_div19: assert property (p_div19) else $error("19-bit word load wrong");

	property p_div27;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		div_load |=> o_divider_word == $past(sr_q[14:0]);
	endproperty
	a_div27: assert property (p_div27) else $error("long word divider not loaded");

	property p_short;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(word_end && cnt_q < tuner_pll_pkg::WORD_SHORT) |=> $stable(o_divider_word);
	endproperty
	a_short: assert property (p_short) else $error("short word changed divider");

	property p_ctrl_keep;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		!end27 |=> $stable(o_pump_current_select) && $stable(o_test_mode_bits)
			&& $stable(o_ratio_select_b);
	endproperty
	a_ctrl_keep: assert property (p_ctrl_keep) else $error("control changed off long word");

	property p_defaults;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		$rose(i_rst_n) |-> o_pump_current_select
			&& o_test_mode_bits == tuner_pll_pkg::TEST_RST
			&& o_ratio_select_b && o_tuning_output_off
			&& o_divider_word == tuner_pll_pkg::DIV_RST
			&& !o_high_band_port && !o_low_sub_band_port;
	endproperty
	a_defaults: assert property (p_defaults) else $error("power-on defaults wrong");

	property p_tune;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		!first_q |-> o_tuning_output_off;
	endproperty
	a_tune: assert property (p_tune) else $error("tuning enabled before first word");

	property p_ratio;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(!o_ratio_select_b |-> o_ref_divider_ratio == tuner_pll_pkg::RATIO_640)
			and ((o_ratio_select_b && o_ratio_select_a)
				|-> o_ref_divider_ratio == tuner_pll_pkg::RATIO_512)
			and ((o_ratio_select_b && !o_ratio_select_a)
				|-> o_ref_divider_ratio == tuner_pll_pkg::RATIO_1024);
	endproperty
	a_ratio: assert property (p_ratio) else $error("reference ratio mismatch");

endmodule

// >>> logic/tuner_pll_pkg.sv
package tuner_pll_pkg;

	// Word lengths and load points, counted in shifted bits
	localparam logic [4:0] WORD_SHORT    = 5'h12;
	localparam logic [4:0] WORD_MID      = 5'h13;
	localparam logic [4:0] WORD_LONG     = 5'h1B;
	localparam logic [4:0] BAND_LOAD_CNT = 5'h04;
	localparam logic [4:0] DIV_LOAD_CNT  = 5'h13;
	localparam logic [4:0] CNT_MAX       = 5'h1F;
	localparam logic [4:0] CNT_ZERO      = 5'h00;
	localparam logic [4:0] CNT_ONE       = 5'h01;

	// Field widths
	localparam int SHIFT_W = 27;
	localparam int DIV_W   = 15;
	localparam int BAND_W  = 4;
	localparam int TEST_W  = 3;
	localparam int RATIO_W = 11;

	// Band bits inside the shift register after four shifts
	localparam int BB_SOUND_TRAP = 3;
	localparam int BB_HIGH_BAND  = 2;
	localparam int BB_UPPER_SUB  = 1;
	localparam int BB_LOW_SUB    = 0;

	// Control byte positions, last eight bits of a long word
	localparam int CB_CP   = 6;
	localparam int CB_T_HI = 5;
	localparam int CB_T_LO = 3;
	localparam int CB_RSA  = 2;
	localparam int CB_RSB  = 1;
	localparam int CB_OS   = 0;

	// Divider bit positions for short words
	localparam int DIV_SHORT_HI = 13;

	// Power-on values
	localparam logic [BAND_W-1:0] BAND_RST = 4'h0;
	localparam logic [DIV_W-1:0]  DIV_RST  = 15'h0000;
	localparam logic              CP_RST   = 1'h1;
	localparam logic [TEST_W-1:0] TEST_RST = 3'h1;
	localparam logic              RSA_RST  = 1'h0;
	localparam logic              RSB_RST  = 1'h1;
	localparam logic              OS_RST   = 1'h0;

	// Reference divider ratios
	localparam logic [RATIO_W-1:0] RATIO_640  = 11'h280;
	localparam logic [RATIO_W-1:0] RATIO_1024 = 11'h400;
	localparam logic [RATIO_W-1:0] RATIO_512  = 11'h200;

	typedef enum logic [2:0] {
		ST_OFF   = 3'h1,
		ST_IDLE  = 3'h2,
		ST_SHIFT = 3'h4
	} load_state_t;

endpackage

// >>> logic/bus_edge_detect.sv
`timescale 1ns/1ps
module bus_edge_detect (
	input  wire logic i_ref_clk,
	input  wire logic i_rst_n,
	input  wire logic i_bus_ce,
	input  wire logic i_bus_clk,
	input  wire logic i_bus_data,
	output logic      o_ce_high,
	output logic      o_ce_fall,
	output logic      o_clk_rise,
	output logic      o_clk_fall,
	output logic      o_data
);

	logic ce_q;
	logic ce_prev_q;
	logic clk_q;
	logic clk_prev_q;
	logic data_q;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			ce_q       <= 1'h0;
			ce_prev_q  <= 1'h0;
			clk_q      <= 1'h0;
			clk_prev_q <= 1'h0;
			data_q     <= 1'h0;
		end else begin
			ce_q       <= i_bus_ce;
			ce_prev_q  <= ce_q;
			clk_q      <= i_bus_clk;
			clk_prev_q <= clk_q;
			data_q     <= i_bus_data;
		end
	end

	assign o_ce_high  = ce_q;
	assign o_ce_fall  = ce_prev_q & ~ce_q;
	assign o_clk_rise = ~clk_prev_q & clk_q;
	assign o_clk_fall = clk_prev_q & ~clk_q;
	assign o_data     = data_q;

endmodule

// >>> bench/three_wire_master_model.sv
`timescale 1ns/1ps
module three_wire_master_model (
	input  wire logic        i_ref_clk,
	input  wire logic        i_go,
	input  wire logic [4:0]  i_len,
	input  wire logic [26:0] i_word,
	input  wire logic [3:0]  i_half,
	output logic             o_ce,
	output logic             o_clk,
	output logic             o_data,
	output logic             o_busy
);
	int h;
	int n;

	initial begin
		o_ce   = 1'b0;
		o_clk  = 1'b0;
		o_data = 1'b0;
		o_busy = 1'b0;
	end

	// One word per request, bus clock parked low between frames
	always begin
		@(posedge i_ref_clk);
		if (i_go && !o_busy) begin
			h = int'(i_half);
			n = int'(i_len);
			o_busy <= 1'b1;
			o_ce   <= 1'b1;
			repeat (h) @(posedge i_ref_clk);
			// Band bits, divider MSB down, then control
			for (int k = n - 1; k >= 0; k--) begin
				o_data <= i_word[k];
				o_clk  <= 1'b1;
				repeat (h) @(posedge i_ref_clk);
				o_clk  <= 1'b0;
				repeat (h) @(posedge i_ref_clk);
			end
			o_ce <= 1'b0;
			repeat (h) @(posedge i_ref_clk);
			o_data <= ~o_data;
			o_busy <= 1'b0;
		end
	end
endmodule

// >>> bench/tb_tuner_pll_three_wire_loader.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
	$display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb_tuner_pll_three_wire_loader;
	logic        i_ref_clk = 1'b0;
	logic        i_rst_n   = 1'b0;
	logic        fmt       = 1'b1;
	logic        go        = 1'b0;
	logic [4:0]  len       = 5'h00;
	logic [26:0] word      = 27'h0000000;
	logic [3:0]  half      = 4'h3;
	logic        ce, bclk, bdata, busy;
	logic        hb, ls, us, st, cp, a, b, off;
	logic [14:0] dv;
	logic [2:0]  tm;
	logic [10:0] ratio;
	logic [3:0]  e_band;
	logic [14:0] e_dv;
	logic [2:0]  e_tm;
	logic        e_cp, e_a, e_b, e_off;
	int          err_count = 0;
	int          cmp_count = 0;

	always #2.5 i_ref_clk = ~i_ref_clk;

	three_wire_master_model master (.i_ref_clk(i_ref_clk), .i_go(go), .i_len(len),
		.i_word(word), .i_half(half), .o_ce(ce), .o_clk(bclk), .o_data(bdata), .o_busy(busy));

	tuner_pll_three_wire_loader dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.i_bus_format_select(fmt), .i_bus_ce(ce), .i_bus_clk(bclk), .i_bus_data(bdata),
		.o_high_band_port(hb), .o_low_sub_band_port(ls), .o_upper_sub_band_port(us),
		.o_sound_trap_port(st), .o_divider_word(dv), .o_pump_current_select(cp),
		.o_test_mode_bits(tm), .o_ratio_select_a(a), .o_ratio_select_b(b),
		.o_ref_divider_ratio(ratio), .o_tuning_output_off(off));

	task automatic results;
		$display("Compares %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic defaults;
		e_band = 4'h0;
		e_dv   = 15'h0000;
		e_cp   = 1'h1;
		e_tm   = 3'h1;
		e_a    = 1'h0;
		e_b    = 1'h1;
		e_off  = 1'h1;
	endtask

	task automatic check;
		logic [10:0] e_ratio;
		e_ratio = !e_b ? tuner_pll_pkg::RATIO_640 :
			(e_a ? tuner_pll_pkg::RATIO_512 : tuner_pll_pkg::RATIO_1024);
		`CHK({st, hb, us, ls}, e_band)
		`CHK(dv, e_dv)
		`CHK(cp, e_cp)
		`CHK(tm, e_tm)
		`CHK(a, e_a)
		`CHK(b, e_b)
		`CHK(ratio, e_ratio)
		`CHK(off, e_off)
	endtask

	task automatic send(input logic [4:0] n, input logic [26:0] w, input logic [3:0] h);
		int k;
		k = 0;
		@(posedge i_ref_clk);
		len  <= n;
		word <= w;
		half <= h;
		go   <= 1'b1;
		@(posedge i_ref_clk);
		while (!busy && k < 20) begin
			@(posedge i_ref_clk);
			k++;
		end
		go <= 1'b0;
		if (!busy) begin
			err_count++;
			results();
		end
		while (busy && k < 3000) begin
			@(posedge i_ref_clk);
			k++;
		end
		if (busy) begin
			err_count++;
			results();
		end
		repeat (4) @(posedge i_ref_clk);
	endtask

	initial begin
		repeat (5) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		defaults();
		check();
		// Short word: band loads, divider and select A stay
		send(5'h0A, {17'h00000, 4'hA, 6'h3F}, 4'h3);
		e_band = 4'hA;
		check();
		send(5'h13, {8'h00, 4'h6, 15'h7123}, 4'h3);
		e_band = 4'h6;
		e_dv   = 15'h7123;
		e_off  = 1'h0;
		check();
		send(5'h12, {9'h000, 4'h9, 14'h0456}, 4'h4);
		e_band = 4'h9;
		e_dv   = 15'h0456;
		e_a    = 1'h1;
		check();
		// Long words walk every select combination, slow master
		for (int i = 0; i < 4; i++) begin
			e_band = 4'(i + 8);
			e_dv   = 15'h4321 + 15'(i);
			e_cp   = i[0];
			e_tm   = 3'(i + 4);
			e_a    = i[1];
			e_b    = ~i[0];
			e_off  = i[1];
			send(5'h1B, {e_band, e_dv, 1'b1, e_cp, e_tm, e_a, e_b, e_off}, 4'h6);
			check();
		end
		// Short words keep control bits other than select A
		send(5'h12, {9'h000, 4'h3, 14'h1234}, 4'h3);
		e_band = 4'h3;
		e_dv   = 15'h1234;
		check();
		send(5'h13, {8'h00, 4'h5, 15'h5A5A}, 4'h3);
		e_band = 4'h5;
		e_dv   = 15'h5A5A;
		e_a    = 1'h0;
		check();
		// Bus ignored outside three-wire mode
		fmt <= 1'b0;
		send(5'h13, {8'h00, 4'hF, 15'h0F0F}, 4'h3);
		check();
		fmt <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		// Second reset mid-run
		i_rst_n <= 1'b0;
		repeat (5) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		defaults();
		check();
		results();
	end
endmodule
